// ==== acisrf_conv_model.sv ====
// Stand-in for the converter core beside the select block.
// Assumes the bench calls convert from one process at a time.
`timescale 1ns/10ps
module acisrf_conv_model (
    input  logic       clk,
    output logic       busy,
    output logic       done,
    output logic [9:0] code
);
    // Idle levels at time zero
    initial begin
        busy = 1'b0;
        done = 1'b0;
        code = 10'h155;
    end
    // Busy for n cycles, then one done cycle carrying the raw code
    task convert(input logic [9:0] c, input int n);
        @(posedge clk);
        busy <= 1'b1;
        repeat (n) @(posedge clk);
        busy <= 1'b0;
        done <= 1'b1;
        code <= c;
        @(posedge clk);
        done <= 1'b0;
        code <= ~c; // Code is not held after done
    endtask
endmodule // acisrf_conv_model

// ==== acisrf_decode.v ====
// Decoder from the 5-bit input and gain code to front end controls.
// Assumes a purely combinational use; the caller registers the outputs.
`timescale 1ns/10ps
`include "acisrf_defs.vh"

module acisrf_decode (
    input  wire [4:0] code,
    output reg  [2:0] pos_sel,
    output reg  [2:0] neg_sel,
    output reg        diff,
    output reg  [1:0] gain,
    output reg        bandgap,
    output reg        ground
);

    // Map each code group onto pins, gain and mode
    always @* begin
        pos_sel = code[2:0];
        neg_sel = 3'h0;
        diff    = 1'b0;
        gain    = `ACISRF_GAIN_1X;
        bandgap = 1'b0;
        ground  = 1'b0;
        case (code[4:3])
            2'h0: begin
                diff = 1'b0;
            end
            2'h1: begin
                // Pair 1-0 or 3-2; even codes pair a pin with itself
                diff    = 1'b1;
                neg_sel = {1'b0, code[2], 1'b0};
                pos_sel = {1'b0, code[2], code[0]};
                gain    = code[1] ? `ACISRF_GAIN_200X : `ACISRF_GAIN_10X;
            end
            2'h2: begin
                diff    = 1'b1;
                neg_sel = 3'h1;
            end
            2'h3: begin
                if (code == `ACISRF_MUX_BANDGAP) begin
                    bandgap = 1'b1;
                end else if (code == `ACISRF_MUX_GROUND) begin
                    ground = 1'b1;
                end else begin
                    diff    = 1'b1;
                    neg_sel = 3'h2;
                end
            end
            default: begin
                diff = 1'b0;
            end
        endcase
    end

endmodule // acisrf_decode

// ==== acisrf_defs.vh ====
// Constants of the converter input select and result format block.
// Assumes inclusion by every design file of the block, by bare name.
`ifndef ACISRF_DEFS_VH
`define ACISRF_DEFS_VH

// Register offsets on the plain register port
`define ACISRF_ADDR_SELECT    3'h0
`define ACISRF_ADDR_RES_LOW   3'h1
`define ACISRF_ADDR_RES_HIGH  3'h2
`define ACISRF_ADDR_IRQ_STAT  3'h3
`define ACISRF_ADDR_IRQ_MASK  3'h4

// Field positions of the selection register
`define ACISRF_REF_HI         7
`define ACISRF_REF_LO         6
`define ACISRF_LADJ_BIT       5
`define ACISRF_MUX_HI         4
`define ACISRF_MUX_LO         0

// Reset values
`define ACISRF_SELECT_RESET   8'h00
`define ACISRF_IRQ_RESET      3'h0

// Reference select codes
`define ACISRF_REF_EXTERNAL   2'h0
`define ACISRF_REF_SUPPLY     2'h1
`define ACISRF_REF_RESERVED   2'h2
`define ACISRF_REF_INTERNAL   2'h3

// Gain codes driven to the analog front end
`define ACISRF_GAIN_1X        2'h0
`define ACISRF_GAIN_10X       2'h1
`define ACISRF_GAIN_200X      2'h2

// Special input codes
`define ACISRF_MUX_BANDGAP    5'h1e
`define ACISRF_MUX_GROUND     5'h1f

// Interrupt status and mask bit positions
`define ACISRF_IRQ_DONE       0
`define ACISRF_IRQ_LOST       1
`define ACISRF_IRQ_SWITCH     2

`endif

// ==== acisrf_result.v ====
// Result pair store with low-then-high read lock and alignment.
// Assumes one-cycle read pulses for the low and high result bytes.
`timescale 1ns/10ps
`include "acisrf_defs.vh"

module acisrf_result (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       load,
    input  wire [9:0] code,
    input  wire       left_adjust,
    input  wire       rd_low,
    input  wire       rd_high,
    output wire [7:0] low_byte,
    output wire [7:0] high_byte,
    output wire       accepted
);

    reg  [9:0]  value;
    reg         locked;
    wire [15:0] shown;

    // Place the 10-bit result in the 16-bit pair
    function [15:0] align;
        input [9:0] v;
        input       ladj;
        begin
            if (ladj)
                align = {v, 6'h00};
            else
                align = {6'h00, v};
        end
    endfunction

    // A load is refused while the pair is half read
    assign accepted = load & ~locked & ~rd_low;

    // Hold the value and the half-read lock
    always @(posedge clk) begin
        if (!reset_n) begin
            value  <= 10'h000;
            locked <= 1'b0;
        end else begin
            if (accepted)
                value <= code;
            if (rd_low)
                locked <= 1'b1;
            else if (rd_high)
                locked <= 1'b0;
        end
    end

    // Alignment follows the live bit, not the conversion
    assign shown     = align(value, left_adjust);
    assign low_byte  = shown[7:0];
    assign high_byte = shown[15:8];

endmodule // acisrf_result

// ==== acisrf_top.v ====
// Top of the converter input select and result format block.
// Holds the selection register, the applied front end selection,
// result coding, the result byte pair and the completion interrupt.
// Assumes a converter core that raises CONV_BUSY over a conversion
// and pulses CONV_DONE for one cycle with the raw code on CONV_CODE.
// Assumes software reads the result pair low byte first.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "acisrf_defs.vh"

// Functional notes
// - Single-ended result is unsigned 0x000 to 0x3ff
// - Differential result is ten-bit two's complement
// - Top result bit is the differential sign
// - Eight-bit selection register, read/write, resets zero
// - Reference and input changes wait for conversion end
// - Reference code selects external, supply or internal
// - Left-adjust bit chooses left or right alignment
// - Alignment change shows at once on result
// - Codes 0-7 single inputs; bandgap; ground
// - Gain pairs 1-0 and 3-2 at 10x, 200x
// - Unity-gain pairs against input 1 or 2
// - Done flag sets when result pair updated
// - Low read blocks updates until high read
// - Left adjust uses bits 15:6, else 9:0
module acisrf_top (
    input  wire       CLK,
    input  wire       RESET_N,
    input  wire [2:0] ADDR,
    input  wire [7:0] WR_DATA,
    input  wire       WR_EN,
    input  wire       RD_EN,
    output reg  [7:0] RD_DATA,
    input  wire       CONV_BUSY,
    input  wire       CONV_DONE,
    input  wire [9:0] CONV_CODE,
    output reg  [1:0] REF_SEL,
    output reg        INTREF_ON,
    output reg  [2:0] POS_SEL,
    output reg  [2:0] NEG_SEL,
    output reg        DIFF_MODE,
    output reg  [1:0] GAIN_SEL,
    output reg        BANDGAP_SEL,
    output reg        GROUND_SEL,
    output reg        DONE_FLAG,
    output reg        IRQ
);

    // Software-visible selection register
    reg  [7:0] adc_input_select;

    // Interrupt status and mask
    reg  [2:0] irq_status;
    reg  [2:0] irq_mask;
    wire [2:0] next_irq_status;
    wire [2:0] irq_event;
    wire [2:0] irq_clear;
    wire [2:0] irq_enable;

    // Selection that the last stored conversion ran with
    reg  [12:0] last_sel;
    wire [12:0] applied_sel;

    // Register access decode
    wire       wr_select;
    wire       wr_status;
    wire       wr_mask;
    wire       rd_low;
    wire       rd_high;
    reg  [7:0] read_word;

    // Fields of the selection register
    wire [1:0] reference_select;
    wire       left_adjust_result;
    wire [4:0] input_gain_select;

    // Decoded front end controls from the written code
    wire [2:0] dec_pos;
    wire [2:0] dec_neg;
    wire       dec_diff;
    wire [1:0] dec_gain;
    wire       dec_bandgap;
    wire       dec_ground;

    // Coded result and the result store
    wire [9:0] coded;
    wire       result_sign_bit;
    wire [7:0] result_low_byte;
    wire [7:0] result_high_byte;
    wire       accepted;
    wire       lost;
    wire       switched;
    wire       apply;

    // Matching of an access against one register offset
    function hit;
        input [2:0] addr;
        input [2:0] offset;
        input       strobe;
        begin
            hit = strobe & (addr == offset);
        end
    endfunction

    // Strobe decode shared by write and read paths
    assign wr_select = hit(ADDR, `ACISRF_ADDR_SELECT, WR_EN);
    assign wr_status = hit(ADDR, `ACISRF_ADDR_IRQ_STAT, WR_EN);
    assign wr_mask   = hit(ADDR, `ACISRF_ADDR_IRQ_MASK, WR_EN);
    assign rd_low    = hit(ADDR, `ACISRF_ADDR_RES_LOW, RD_EN);
    assign rd_high   = hit(ADDR, `ACISRF_ADDR_RES_HIGH, RD_EN);

    // Field split of the selection register
    assign reference_select =
        adc_input_select[`ACISRF_REF_HI:`ACISRF_REF_LO];
    assign left_adjust_result = adc_input_select[`ACISRF_LADJ_BIT];
    assign input_gain_select =
        adc_input_select[`ACISRF_MUX_HI:`ACISRF_MUX_LO];

    // Selection register: all eight bits read/write
    always @(posedge CLK) begin
        if (!RESET_N) begin
            adc_input_select <= `ACISRF_SELECT_RESET;
        end else if (wr_select) begin
            // Reference and input fields are stored at once; they reach the front end
            // only while the converter is idle; the adjust bit acts on the result at once
            adc_input_select[`ACISRF_REF_HI:`ACISRF_REF_LO] <=
                WR_DATA[`ACISRF_REF_HI:`ACISRF_REF_LO];
            adc_input_select[`ACISRF_LADJ_BIT] <=
                WR_DATA[`ACISRF_LADJ_BIT];
            adc_input_select[`ACISRF_MUX_HI:`ACISRF_MUX_LO] <=
                WR_DATA[`ACISRF_MUX_HI:`ACISRF_MUX_LO];
        end
    end

    // Decode the input and gain code of the register
    acisrf_decode u_decode (
        .code    (input_gain_select),
        .pos_sel (dec_pos),
        .neg_sel (dec_neg),
        .diff    (dec_diff),
        .gain    (dec_gain),
        .bandgap (dec_bandgap),
        .ground  (dec_ground)
    );

    // New selection reaches the front end only between conversions
    assign apply = ~CONV_BUSY;

    // Applied reference choice, frozen while converting
    always @(posedge CLK) begin
        if (!RESET_N) begin
            REF_SEL   <= `ACISRF_REF_EXTERNAL;
            INTREF_ON <= 1'b0;
        end else if (apply) begin
            // Reserved reference code is passed on as written
            REF_SEL   <= reference_select;
            // Internal reference runs only for its own code
            INTREF_ON <= (reference_select ==
                          `ACISRF_REF_INTERNAL);
        end
    end

    // Applied input pins and gain, frozen while converting
    always @(posedge CLK) begin
        if (!RESET_N) begin
            POS_SEL     <= 3'h0;
            NEG_SEL     <= 3'h0;
            DIFF_MODE   <= 1'b0;
            GAIN_SEL    <= `ACISRF_GAIN_1X;
            BANDGAP_SEL <= 1'b0;
            GROUND_SEL  <= 1'b0;
        end else if (apply) begin
            // Pins, mode and gain switch together, never half applied
            POS_SEL     <= dec_pos;
            NEG_SEL     <= dec_neg;
            DIFF_MODE   <= dec_diff;
            GAIN_SEL    <= dec_gain;
            BANDGAP_SEL <= dec_bandgap;
            GROUND_SEL  <= dec_ground;
        end
    end

    // Packed view of every applied front end control but INTREF_ON, which follows REF_SEL, so that any
    // change of reference, pins, mode or gain marks the next result
    assign applied_sel = {REF_SEL, POS_SEL, NEG_SEL, DIFF_MODE,
                          GAIN_SEL, BANDGAP_SEL, GROUND_SEL};

    // Result coding: differential raw code is offset binary
    // with 0x200 at zero difference; flipping the top bit gives
    // two's complement, so the top bit alone carries the sign.
    // Single-ended codes pass unchanged as unsigned values.
    assign result_sign_bit = DIFF_MODE ? ~CONV_CODE[9] :
                             CONV_CODE[9];
    assign coded = {result_sign_bit, CONV_CODE[8:0]};

    // Result pair with half-read lock and live alignment
    acisrf_result u_result (
        .clk         (CLK),
        .reset_n     (RESET_N),
        .load        (CONV_DONE),
        .code        (coded),
        .left_adjust (left_adjust_result),
        .rd_low      (rd_low),
        .rd_high     (rd_high),
        .low_byte    (result_low_byte),
        .high_byte   (result_high_byte),
        .accepted    (accepted)
    );

    // A finished conversion refused by the lock is lost; the pair
    // keeps the bytes of one conversion, so the low and high reads
    // never mix an old and a new result
    assign lost = CONV_DONE & ~accepted;

    // Conversion after a change of selection may be inaccurate
    assign switched = accepted & (applied_sel != last_sel);

    // Remember the selection of the last stored conversion
    always @(posedge CLK) begin
        if (!RESET_N) begin
            last_sel <= 13'h0000;
        end else if (accepted) begin
            last_sel <= applied_sel;
        end
    end

    // Events that set the sticky status bits
    assign irq_event[`ACISRF_IRQ_DONE]   = accepted;
    assign irq_event[`ACISRF_IRQ_LOST]   = lost;
    assign irq_event[`ACISRF_IRQ_SWITCH] = switched;

    // Write-one clear pattern of the status register
    assign irq_clear = wr_status ? WR_DATA[2:0] : 3'h0;

    // Sticky status bits: set wins over a write-one clear, so an
    // event in the clearing cycle is never missed
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_status
            assign next_irq_status[g] = irq_event[g] |
                                        (irq_status[g] & ~irq_clear[g]);
        end
    endgenerate

    // Status register
    always @(posedge CLK) begin
        if (!RESET_N) begin
            irq_status <= `ACISRF_IRQ_RESET;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Mask register, same layout as the status
    always @(posedge CLK) begin
        if (!RESET_N) begin
            irq_mask <= `ACISRF_IRQ_RESET;
        end else if (wr_mask) begin
            irq_mask <= WR_DATA[2:0];
        end
    end

    // Mask that holds after this edge, so a mask write acts at once
    assign irq_enable = wr_mask ? WR_DATA[2:0] : irq_mask;

    // Done flag follows the next status, so it rises with the store
    always @(posedge CLK) begin
        if (!RESET_N) begin
            DONE_FLAG <= 1'b0;
        end else begin
            DONE_FLAG <= next_irq_status[`ACISRF_IRQ_DONE];
        end
    end

    // Level interrupt while an unmasked status bit is set
    always @(posedge CLK) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(next_irq_status & irq_enable);
        end
    end

    // Read multiplexer over the register offsets
    always @* begin
        case (ADDR)
            `ACISRF_ADDR_SELECT:   read_word = adc_input_select;
            // Software waits for the done flag before reading
            `ACISRF_ADDR_RES_LOW:  read_word = result_low_byte;
            `ACISRF_ADDR_RES_HIGH: read_word = result_high_byte;
            `ACISRF_ADDR_IRQ_STAT: read_word = {5'h00, irq_status};
            `ACISRF_ADDR_IRQ_MASK: read_word = {5'h00, irq_mask};
            default:               read_word = 8'h00;
        endcase
    end

    // Read data stand in the cycle after the read strobe only
    always @(posedge CLK) begin
        if (!RESET_N) begin
            RD_DATA <= 8'h00;
        end else if (RD_EN) begin
            RD_DATA <= read_word;
        end else begin
            RD_DATA <= 8'h00;
        end
    end

endmodule // acisrf_top

// ==== acisrf_top_checker.sv ====
// Port checker for the input select and result format block.
// Assumes it is bound to acisrf_top and sees only its ports.
`timescale 1ns/10ps
module acisrf_top_checker (
    input logic       CLK,
    input logic       RESET_N,
    input logic [2:0] ADDR,
    input logic [7:0] WR_DATA,
    input logic       WR_EN,
    input logic       RD_EN,
    input logic [7:0] RD_DATA,
    input logic       CONV_BUSY,
    input logic       CONV_DONE,
    input logic [1:0] REF_SEL,
    input logic       INTREF_ON,
    input logic [2:0] POS_SEL,
    input logic [2:0] NEG_SEL,
    input logic       DIFF_MODE,
    input logic [1:0] GAIN_SEL,
    input logic       BANDGAP_SEL,
    input logic       GROUND_SEL,
    input logic       DONE_FLAG,
    input logic       IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_sel_hold: assert property (CONV_BUSY |=>
        $stable({REF_SEL, POS_SEL, NEG_SEL, GAIN_SEL, DIFF_MODE}))
        else $error("selection moved during conversion");
    a_intref_map: assert property (
        INTREF_ON == (REF_SEL == 2'h3))
        else $error("internal reference enable wrong");
    a_done_cause: assert property (
        $rose(DONE_FLAG) |-> $past(CONV_DONE))
        else $error("done flag without conversion end");
    a_done_sticky: assert property (DONE_FLAG &&
        !(WR_EN && ADDR == 3'h3 && WR_DATA[0]) |=> DONE_FLAG)
        else $error("done flag lost without clear");
    a_rd_idle: assert property (!RD_EN |=> RD_DATA == 8'h00)
        else $error("read data outside read slot");
    a_sel_back: assert property (WR_EN && ADDR == 3'h0 ##2
        RD_EN && ADDR == 3'h0 && !$past(WR_EN)
        |=> RD_DATA == $past(WR_DATA, 3))
        else $error("selection readback wrong");
    a_gain_pair: assert property (GAIN_SEL != 2'h0 |->
        DIFF_MODE && !NEG_SEL[0] && !NEG_SEL[2] && GAIN_SEL != 2'h3)
        else $error("gain on a non gain pair");
    a_special_in: assert property (BANDGAP_SEL || GROUND_SEL
        |-> !DIFF_MODE && !(BANDGAP_SEL && GROUND_SEL))
        else $error("bandgap or ground select wrong");
    c_done: cover property ($rose(DONE_FLAG));
    c_irq: cover property ($rose(IRQ));
    c_busy_wr: cover property (CONV_BUSY && WR_EN);
endmodule // acisrf_top_checker
bind acisrf_top acisrf_top_checker chk_i (.*);

// ==== acisrf_top_test.sv ====
// Bench for the input select and result format block.
// Assumes the converter stand-in model drives the conversion link.
`timescale 1ns/10ps
`include "acisrf_defs.vh"
module acisrf_top_test;
    logic       CLK = 1'b0;
    logic       RESET_N = 1'b0;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WR_DATA = 8'h00;
    logic       WR_EN = 1'b0;
    logic       RD_EN = 1'b0;
    wire  [7:0] RD_DATA;
    wire        CONV_BUSY, CONV_DONE, INTREF_ON, DIFF_MODE;
    wire  [9:0] CONV_CODE;
    wire  [1:0] REF_SEL, GAIN_SEL;
    wire  [2:0] POS_SEL, NEG_SEL;
    wire        BANDGAP_SEL, GROUND_SEL, DONE_FLAG, IRQ;
    int         n_errors = 0;
    int         checks = 0;
    int         cycles = 0;
    int         i;

    acisrf_top dut (
        .CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
        .CONV_BUSY(CONV_BUSY), .CONV_DONE(CONV_DONE),
        .CONV_CODE(CONV_CODE), .REF_SEL(REF_SEL), .INTREF_ON(INTREF_ON),
        .POS_SEL(POS_SEL), .NEG_SEL(NEG_SEL), .DIFF_MODE(DIFF_MODE),
        .GAIN_SEL(GAIN_SEL), .BANDGAP_SEL(BANDGAP_SEL),
        .GROUND_SEL(GROUND_SEL), .DONE_FLAG(DONE_FLAG), .IRQ(IRQ));
    acisrf_conv_model cm (.clk(CLK), .busy(CONV_BUSY),
        .done(CONV_DONE), .code(CONV_CODE));

    always #25 CLK = ~CLK;

    // Hang guard
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            end_sim;
        end
    end

    task end_sim;
        if (n_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("Error %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR_EN <= 1'b1;
        ADDR <= a;
        WR_DATA <= d;
        @(posedge CLK);
        WR_EN <= 1'b0;
    endtask
    task rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge CLK);
        RD_EN <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD_EN <= 1'b0;
        #1 chk({8'h00, RD_DATA & m}, {8'h00, e});
    endtask
    // One conversion, then low and high result bytes
    task conv(input logic [9:0] c, input logic [7:0] lo, hi);
        idle(2);
        cm.convert(c, 3);
        rd(`ACISRF_ADDR_RES_LOW, 8'hff, lo);
        rd(`ACISRF_ADDR_RES_HIGH, 8'hff, hi);
    endtask
    // Expected pos, neg, diff, gain, bandgap, ground for a code
    function automatic logic [10:0] edec(input logic [4:0] c);
        if (c[4:3] == 2'b00)
            edec = {c[2:0], 3'h0, 3'h0, 2'b00};
        else if (c[4:3] == 2'b01)
            edec = {1'b0, c[2], c[0], 1'b0, c[2], 1'b0, 1'b1,
                    c[1] ? 2'h2 : 2'h1, 2'b00};
        else if (c[4:3] == 2'b10)
            edec = {c[2:0], 3'h1, 3'h4, 2'b00};
        else if (c[2:1] == 2'b11)
            edec = {c[2:0], 3'h0, 3'h0, ~c[0], c[0]};
        else
            edec = {c[2:0], 3'h2, 3'h4, 2'b00};
    endfunction

    // Main sequence
    initial begin
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        rd(`ACISRF_ADDR_SELECT, 8'hff, 8'h00);
        rd(`ACISRF_ADDR_IRQ_STAT, 8'h07, 8'h00);
        for (i = 0; i < 4; i++) begin
            // Nothing drives the external reference pin here
            wr(`ACISRF_ADDR_SELECT, {i[1:0], 6'h00});
            idle(2);
            chk({14'h0, REF_SEL}, {14'h0, i[1:0]});
            chk({15'h0, INTREF_ON}, {15'h0, i == 3});
        end
        for (i = 0; i < 32; i++) begin
            wr(`ACISRF_ADDR_SELECT, {3'h0, i[4:0]});
            idle(2);
            chk({5'h0, POS_SEL, NEG_SEL, DIFF_MODE, GAIN_SEL, BANDGAP_SEL,
                GROUND_SEL}, {5'h0, edec(i[4:0])});
        end
        wr(`ACISRF_ADDR_SELECT, 8'hed);
        rd(`ACISRF_ADDR_SELECT, 8'hff, 8'hed);
        wr(`ACISRF_ADDR_IRQ_MASK, 8'h01);
        wr(`ACISRF_ADDR_IRQ_STAT, 8'h07);
        conv(10'h070, 8'h00, 8'h9c);
        chk({14'h0, DONE_FLAG, IRQ}, 16'h0003);
        wr(`ACISRF_ADDR_SELECT, 8'hcd);
        rd(`ACISRF_ADDR_RES_LOW, 8'hff, 8'h70);
        rd(`ACISRF_ADDR_RES_HIGH, 8'hff, 8'h02);
        wr(`ACISRF_ADDR_IRQ_MASK, 8'h00);
        idle(2);
        chk({15'h0, IRQ}, 16'h0000);
        wr(`ACISRF_ADDR_IRQ_STAT, 8'h07);
        idle(2);
        chk({15'h0, DONE_FLAG}, 16'h0000);
        wr(`ACISRF_ADDR_SELECT, 8'h50);
        conv(10'h000, 8'h00, 8'h02);
        conv(10'h3ff, 8'hff, 8'h01);
        wr(`ACISRF_ADDR_SELECT, 8'h40);
        conv(10'h3ff, 8'hff, 8'h03);
        conv(10'h000, 8'h00, 8'h00);
        fork
            cm.convert(10'h2aa, 12);
            begin
                idle(2);
                wr(`ACISRF_ADDR_SELECT, 8'hc3);
                idle(2);
                chk({13'h0, POS_SEL, REF_SEL}, 16'h0001);
            end
        join
        idle(2);
        chk({13'h0, POS_SEL, REF_SEL}, 16'h000f);
        rd(`ACISRF_ADDR_RES_LOW, 8'hff, 8'haa);
        cm.convert(10'h133, 3);
        rd(`ACISRF_ADDR_RES_HIGH, 8'hff, 8'h02);
        rd(`ACISRF_ADDR_IRQ_STAT, 8'h07, 8'h07);
        rd(`ACISRF_ADDR_RES_LOW, 8'hff, 8'haa);
        rd(`ACISRF_ADDR_RES_HIGH, 8'hff, 8'h02);
        end_sim;
    end
endmodule // acisrf_top_test
